// ==== hdl/fidr_host.sv ====
// Host that drives the flash autoselect readout pins
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Device returns ID codes on low byte.
// RULE_02: Hold A9 at high ID voltage.
// RULE_03: CS low, OE low, WE high, A6 low.
// RULE_04: Device ID read over three selects.
// RULE_05: Third ID byte shows boot placement.
// RULE_06: Protect verify: sector on A20-A12, A1=H A0=L.
// RULE_07: Secured indicator 82h locked, 02h open.
// RULE_08: Bank address on A20-A18 otherwise.
// RULE_09: Command route needs no high voltage.
// RULE_10: Byte mode adds A-1, word uses A0.
// RULE_11: Upper main sectors span 64K, six bits.
// RULE_12: Secured region at bottom, 256/128.
// RULE_13: Without ID mode, reads return array.
module fidr_host (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // User request
  input wire logic i_start,
  input wire logic [2:0] i_kind,
  input wire logic [fidr_pkg::BANK_W-1:0] i_bank,
  input wire logic [fidr_pkg::SECT_W-1:0] i_sector_addr,
  input wire logic i_word_mode,
  // User answer
  output logic o_busy,
  output logic o_done,
  output logic [fidr_pkg::DATA_W-1:0] o_result,
  output logic o_flag,
  output logic o_main_sector,
  // Flash pins
  output logic o_chip_sel_n,
  output logic o_out_en_n,
  output logic o_wr_en_n,
  output logic [fidr_pkg::ADDR_W-1:0] o_addr,
  output logic o_byte_lsb,
  output logic o_width_word,
  output logic o_id_high_voltage,
  input wire logic [fidr_pkg::DATA_W-1:0] i_dq
);
  // ***************************************************************
  // Types and helpers
  // ***************************************************************
  typedef enum logic [2:0] {
    K_MANUF, K_DEV1, K_DEV2, K_DEV3, K_PROT, K_SECR
  } fidr_kind_type;
  typedef enum {S_IDLE, S_SETUP, S_READ, S_DONE} fidr_state_type;
  // Low address select for a read kind [RULE_03] [RULE_04]
  function automatic logic [3:0] sel_of(input logic [2:0] k);
    case (k)
      K_DEV1: sel_of = fidr_pkg::SEL_DEV1;
      K_DEV2: sel_of = fidr_pkg::SEL_DEV2;
      K_DEV3: sel_of = fidr_pkg::SEL_DEV3;
      K_PROT: sel_of = fidr_pkg::SEL_PROT; // [RULE_06]
      K_SECR: sel_of = fidr_pkg::SEL_SECR; // [RULE_07]
      default: sel_of = fidr_pkg::SEL_MANUF;
    endcase
  endfunction
  // ***************************************************************
  // State
  // ***************************************************************
  fidr_state_type state, next_state; // Sequencer state
  logic [fidr_pkg::CNT_W-1:0] cnt, next_cnt; // Wait counter
  logic [2:0] kind, next_kind; // Latched request kind
  logic busy, next_busy;
  logic done, next_done;
  logic [fidr_pkg::DATA_W-1:0] result, next_result;
  logic flag, next_flag;
  logic msec, next_msec;
  logic cs_n, next_cs_n;
  logic oe_n, next_oe_n;
  logic we_n, next_we_n;
  logic [fidr_pkg::ADDR_W-1:0] addr, next_addr;
  logic byte_lsb, next_byte_lsb;
  logic width_word, next_width_word;
  logic vid, next_vid;
  logic [6:0] sect_num; // Decoded sector number, unused beyond flag
  logic main_hit; // Sector number is MAIN_FIRST (48) or above
  logic sec_hit; // Address lands in secured region
  // ***************************************************************
  // Address decode of the requested sector
  // ***************************************************************
  fidr_decode u_decode (
    .i_sector_addr(i_sector_addr),
    .i_low_addr(8'h00),
    .i_word_mode(i_word_mode),
    .i_byte_lsb(1'b0),
    .o_sector_num(sect_num),
    .o_main_sector(main_hit),
    .o_secured_hit(sec_hit)
  );
  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_kind = kind;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    next_flag = flag;
    next_msec = msec;
    next_cs_n = cs_n;
    next_oe_n = oe_n;
    next_we_n = 1'b1; // Never writes: WE stays high [RULE_03]
    next_addr = addr;
    next_byte_lsb = 1'b0;
    next_width_word = width_word;
    next_vid = vid;
    case (state)
      S_IDLE: begin
        if (i_start) begin
          // Pins set up before OE falls, high voltage on A9 [RULE_02]
          next_kind = i_kind;
          next_busy = 1'b1;
          next_vid = 1'b1; // Fixture method only [RULE_09]
          next_width_word = i_word_mode; // [RULE_10]
          next_addr = '0;
          next_addr[3:0] = sel_of(i_kind);
          next_addr[fidr_pkg::A6_BIT] = 1'b0; // [RULE_03]
          if (i_kind == K_PROT) begin
            next_addr[fidr_pkg::SECT_LSB +: fidr_pkg::SECT_W] =
              i_sector_addr; // [RULE_06]
          end else begin
            next_addr[fidr_pkg::BANK_LSB +: fidr_pkg::BANK_W] =
              i_bank; // [RULE_08]
          end
          next_msec = main_hit && !sec_hit; // [RULE_11] [RULE_12]
          next_cs_n = 1'b0; // [RULE_03]
          next_cnt = fidr_pkg::CNT_W'(fidr_pkg::SETUP_CYC);
          next_state = S_SETUP;
        end
      end
      S_SETUP: begin
        // Hold setup, then lower OE for the read
        if (cnt <= 1) begin
          next_oe_n = 1'b0; // [RULE_03]
          next_cnt = fidr_pkg::CNT_W'(fidr_pkg::ACC_CYC);
          next_state = S_READ;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_READ: begin
        if (cnt <= 1) begin
          // Sample low byte; upper byte kept only in word mode [RULE_01]
          next_result = width_word ? i_dq : {8'h00, i_dq[7:0]}; // [RULE_04]
          case (kind)
            K_PROT: next_flag = i_dq[fidr_pkg::PROT_BIT]; // [RULE_06]
            K_SECR: next_flag = i_dq[fidr_pkg::LOCK_BIT]; // [RULE_07]
            // Nonzero third byte means top boot [RULE_05]
            K_DEV3: next_flag = (i_dq[7:0] != fidr_pkg::DEV3_BOTTOM);
            default: next_flag = 1'b0;
          endcase
          next_oe_n = 1'b1;
          next_cs_n = 1'b1;
          next_vid = 1'b0; // Drop voltage: reads revert to array [RULE_13]
          next_state = S_DONE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      S_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end
  // ***************************************************************
  // Registers; pins idle deselected after reset
  // ***************************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= S_IDLE;
      cnt <= '0;
      kind <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
      flag <= 1'b0;
      msec <= 1'b0;
      cs_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= '0;
      byte_lsb <= 1'b0;
      width_word <= 1'b0;
      vid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      kind <= next_kind;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
      flag <= next_flag;
      msec <= next_msec;
      cs_n <= next_cs_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      addr <= next_addr;
      byte_lsb <= next_byte_lsb;
      width_word <= next_width_word;
      vid <= next_vid;
    end
  end
  // ***************************************************************
  // Outputs straight from flip-flops
  // ***************************************************************
  assign o_busy = busy;
  assign o_done = done;
  assign o_result = result;
  assign o_flag = flag;
  assign o_main_sector = msec;
  assign o_chip_sel_n = cs_n;
  assign o_out_en_n = oe_n;
  assign o_wr_en_n = we_n;
  assign o_addr = addr;
  assign o_byte_lsb = byte_lsb;
  assign o_width_word = width_word;
  assign o_id_high_voltage = vid;
endmodule // fidr_host

// ==== inc/fidr_pkg.sv ====
// Package: pin map, autoselect codes and timing for the ID readout host
package fidr_pkg;
  // ***************************************************************
  // Address and data widths
  // ***************************************************************
  localparam int unsigned ADDR_W = 21;       // A20..A0 (word mode)
  localparam int unsigned DATA_W = 16;       // DQ15..DQ0
  localparam int unsigned SECT_W = 9;        // A20..A12 sector field
  localparam int unsigned BANK_W = 3;        // A20..A18 bank field
  localparam int unsigned SECT_LSB = 12;     // Sector field low bit
  localparam int unsigned BANK_LSB = 18;     // Bank field low bit
  // ***************************************************************
  // Low address selects (A3..A0) for each identifier read
  // ***************************************************************
  localparam logic [3:0] SEL_MANUF = 4'h0;   // A1=L A0=L
  localparam logic [3:0] SEL_DEV1 = 4'h1;    // LLLH
  localparam logic [3:0] SEL_DEV2 = 4'he;    // HHHL
  localparam logic [3:0] SEL_DEV3 = 4'hf;    // HHHH
  localparam logic [3:0] SEL_PROT = 4'h2;    // A1=H A0=L
  localparam logic [3:0] SEL_SECR = 4'h3;    // A1=H A0=H
  localparam int unsigned A6_BIT = 6;        // Must be low for all reads
  // ***************************************************************
  // Fixed response values
  // ***************************************************************
  localparam logic [7:0] DEV3_BOTTOM = 8'h00; // Third ID byte, bottom
  localparam logic [7:0] SECR_LOCKED = 8'h82; // Region factory locked
  localparam logic [7:0] SECR_OPEN = 8'h02;   // Region not locked
  localparam int unsigned PROT_BIT = 0;       // Protection flag bit
  localparam int unsigned LOCK_BIT = 7;       // Lock flag bit
  // ***************************************************************
  // Bottom-boot decode
  // ***************************************************************
  localparam logic [5:0] SECR_SECT_HI = 6'h00;   // Region sector A20..A15
  localparam logic [7:0] SECR_BYTE_END = 8'hff;  // Last byte offset
  localparam logic [6:0] SECR_WORD_END = 7'h7f;  // Last word offset
  localparam logic [6:0] MAIN_FIRST = 7'd48;     // First flagged main sector; 64K sectors start at 8
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ = 200;         // Reference clock
  localparam int unsigned T_SETUP_NS = 100;      // Address/VID setup
  localparam int unsigned T_ACC_NS = 120;        // Read access wait
  localparam int unsigned SETUP_CYC =
    (T_SETUP_NS * CLK_MHZ + 999) / 1000;         // Rounded up
  localparam int unsigned ACC_CYC =
    (T_ACC_NS * CLK_MHZ + 999) / 1000;           // Rounded up
  localparam int unsigned CNT_W = 8;             // Wait counter width
endpackage : fidr_pkg

// ==== hdl/fidr_decode.sv ====
// Bottom-boot sector and secured-region address decode
`timescale 1ns/1ps
module fidr_decode (
  // Address in
  input wire logic [fidr_pkg::SECT_W-1:0] i_sector_addr,
  input wire logic [7:0] i_low_addr,
  input wire logic i_word_mode,
  input wire logic i_byte_lsb,
  // Decode out
  output logic [6:0] o_sector_num,
  output logic o_main_sector,
  output logic o_secured_hit
);
  // ***************************************************************
  // Sector number: 8 small sectors then one per upper six bits
  // ***************************************************************
  always_comb begin
    if (i_sector_addr[8:3] == 6'h00) begin
      // Boot sectors SA0..SA7 use all nine bits
      o_sector_num = {4'h0, i_sector_addr[2:0]};
    end else begin
      // Upper main sectors ignore the low three bits [RULE_11]
      o_sector_num = 7'(i_sector_addr[8:3]) + 7'd7;
    end
    o_main_sector = (o_sector_num >= fidr_pkg::MAIN_FIRST); // [RULE_11]
  end
  // ***************************************************************
  // Secured region at bottom: 256 bytes or 128 words [RULE_12]
  // ***************************************************************
  always_comb begin
    if (i_word_mode) begin
      o_secured_hit = (i_sector_addr == 9'h000) && (i_low_addr[7] == 1'b0)
        && (i_low_addr[6:0] <= fidr_pkg::SECR_WORD_END); // [RULE_10]
    end else begin
      // Byte mode adds A-1 below A0
      o_secured_hit = (i_sector_addr == 9'h000) && (i_low_addr[7] == 1'b0)
        && ({i_low_addr[6:0], i_byte_lsb}
        <= fidr_pkg::SECR_BYTE_END); // [RULE_10]
    end
  end
endmodule // fidr_decode

// ==== tb/fidr_host_checker.sv ====
// Checker of the pin sequence of the ID readout host
`timescale 1ns/1ps
module fidr_host_checker (
  // Clock, reset and user side
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [2:0] i_kind,
  input wire logic [2:0] i_bank,
  input wire logic [8:0] i_sector_addr,
  input wire logic o_width_word,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [15:0] o_result,
  // Flash pins
  input wire logic o_chip_sel_n,
  input wire logic o_out_en_n,
  input wire logic o_wr_en_n,
  input wire logic [20:0] o_addr,
  input wire logic o_byte_lsb,
  input wire logic o_id_high_voltage
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // Write enable stays off, byte lsb stays low
  property p_fixed; o_wr_en_n && !o_byte_lsb; endproperty
  a_fixed: assert property (p_fixed)
    else $error("write enable or byte lsb wrong");
  // While selected, A6 low and raised voltage on
  property p_sel; !o_chip_sel_n |-> !o_addr[6] && o_id_high_voltage;
  endproperty
  a_sel: assert property (p_sel)
    else $error("A6 or raised voltage wrong");
  // Raised voltage set up long before the output enable
  property p_setup; $fell(o_out_en_n) |->
    !o_chip_sel_n && $past(o_id_high_voltage, 20); endproperty
  a_setup: assert property (p_setup)
    else $error("setup before output enable short");
  // Output enable held for the whole access time
  property p_access; $fell(o_out_en_n) |->
    ##23 !o_out_en_n ##1 (o_out_en_n && o_chip_sel_n); endproperty
  a_access: assert property (p_access)
    else $error("access window wrong");
  // Answer comes a fixed time after the request
  property p_answer; i_start && !o_busy |-> ##46 o_done; endproperty
  a_answer: assert property (p_answer)
    else $error("done late or missing");
  // Byte width leaves the upper result byte zero; the width pin is used
  // since the user input may already carry the next request
  property p_upper; o_done && !o_width_word |-> o_result[15:8] == 8'h00;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper byte not zero");
  property p_prot; $fell(o_chip_sel_n) && $past(i_kind) == 3'h4 |->
    o_addr[20:12] == $past(i_sector_addr) && o_addr[1:0] == 2'h2;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protect verify address wrong");
  property p_bank; $fell(o_chip_sel_n) && $past(i_kind) != 3'h4 |->
    o_addr[20:18] == $past(i_bank); endproperty
  a_bank: assert property (p_bank)
    else $error("bank address wrong");
  property p_dev; $fell(o_chip_sel_n) && $past(i_kind) inside {[1:3]}
    |-> o_addr[3:0] == ($past(i_kind) == 3'h1 ? fidr_pkg::SEL_DEV1 :
    $past(i_kind) == 3'h2 ? fidr_pkg::SEL_DEV2 : fidr_pkg::SEL_DEV3);
  endproperty
  a_dev: assert property (p_dev)
    else $error("device id select wrong");
  property p_low; $fell(o_chip_sel_n) && $past(i_kind) inside {0, [5:7]}
    |-> o_addr[1:0] == {2{$past(i_kind) == 3'h5}}; endproperty
  a_low: assert property (p_low)
    else $error("low select wrong");
endmodule // fidr_host_checker
bind fidr_host fidr_host_checker chk_u (.*);

// ==== tb/fidr_flash_model.sv ====
// Behavioural flash answering identification reads
`timescale 1ns/1ps
module fidr_flash_model #(
  parameter logic [7:0] MANUF_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEV_ID1 = 8'h3c,  // Arbitrary value
  parameter logic [7:0] DEV_ID2 = 8'hc3,  // Arbitrary value
  parameter logic [7:0] DEV_HI = 8'h96    // Arbitrary value
) (
  // Pins and strap choices
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [20:0] i_addr,
  input wire logic i_word,
  input wire logic i_vid,
  input wire logic i_top,
  input wire logic i_locked,
  output logic [15:0] o_dq
);
  logic [15:0] val;  // Value the device presents
  logic [15:0] last; // Last driven value, inverted once released
  logic drive;       // Read cycle in progress
  logic [7:0] lo;
  logic dev_sel;     // One of the three device id selects
  assign drive = !i_cs_n && !i_oe_n && i_we_n;
  assign dev_sel = i_addr[3:0] inside {4'h1, 4'he, 4'hf};
  always_comb begin
    // Full select first, since HHHL overlaps the protect select
    if (i_addr[3:0] == 4'h1) lo = DEV_ID1;
    else if (i_addr[3:0] == 4'he) lo = DEV_ID2;
    else if (i_addr[3:0] == 4'hf) lo = {7'h00, i_top};
    else if (i_addr[1:0] == 2'h2)
      lo = {7'h00, i_addr[20] ^ i_addr[17]};
    else if (i_addr[1:0] == 2'h3) lo = {i_locked, 7'h02};
    else lo = MANUF_ID;
    // Upper byte is a fixed code only for device id in word width
    // Don't-care byte follows the address so it never feeds back on last
    val = {(i_word && dev_sel) ? DEV_HI : ~i_addr[15:8], lo};
    if (!i_vid || i_addr[6]) val = ~i_addr[15:0];
  end
  initial last = 16'h0000;
  always @* if (drive) last = val;
  assign o_dq = drive ? val : ~last;
endmodule // fidr_flash_model

// ==== tb/test_fidr_host.sv ====
// Self-checking bench of the ID readout host
`timescale 1ns/1ps
module test_fidr_host;
  typedef struct packed {
    logic [15:0] val; logic [15:0] mask; logic flag; logic main;
  } fidr_note_type;
  fidr_note_type notes[$]; // Expected results in order
  fidr_note_type nt;
  int bad_count = 0;
  int samples_checked = 0;
  logic i_ref_clk = 1'b0, i_arst_n = 1'b0, i_start = 1'b0;
  logic [2:0] i_kind = 3'h0, i_bank = 3'h0;
  logic [8:0] i_sector_addr = 9'h000;
  logic i_word_mode = 1'b0, top = 1'b0, locked = 1'b0;
  logic o_busy, o_done, o_flag, o_main_sector, o_chip_sel_n, o_out_en_n;
  logic o_wr_en_n, o_byte_lsb, o_width_word, o_id_high_voltage;
  logic [15:0] o_result, i_dq;
  logic [20:0] o_addr;
  always #2.5 i_ref_clk = ~i_ref_clk;
  fidr_host dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_start(i_start), .i_kind(i_kind), .i_bank(i_bank),
    .i_sector_addr(i_sector_addr), .i_word_mode(i_word_mode),
    .o_busy(o_busy), .o_done(o_done), .o_result(o_result),
    .o_flag(o_flag), .o_main_sector(o_main_sector),
    .o_chip_sel_n(o_chip_sel_n), .o_out_en_n(o_out_en_n),
    .o_wr_en_n(o_wr_en_n), .o_addr(o_addr), .o_byte_lsb(o_byte_lsb),
    .o_width_word(o_width_word), .o_id_high_voltage(o_id_high_voltage),
    .i_dq(i_dq));
  fidr_flash_model flash_u (.i_cs_n(o_chip_sel_n), .i_oe_n(o_out_en_n),
    .i_we_n(o_wr_en_n), .i_addr(o_addr), .i_word(o_width_word),
    .i_vid(o_id_high_voltage), .i_top(top), .i_locked(locked),
    .o_dq(i_dq));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d checked, %0d bad", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Start one read at a falling edge, note what should come back
  task automatic read(logic [2:0] kind, logic word);
    logic [8:0] s;
    logic dev;
    int n;
    s = 9'($urandom);
    dev = kind inside {[1:3]};
    nt.val[7:0] = kind == 1 ? 8'h3c : kind == 2 ? 8'hc3 :
      kind == 3 ? {7'h00, top} : kind == 4 ? {7'h00, s[8] ^ s[5]} :
      kind == 5 ? (locked ? 8'h82 : 8'h02) : 8'h5a;
    nt.val[15:8] = (word && dev) ? 8'h96 : 8'h00;
    nt.mask = (word && !dev) ? 16'h00ff : 16'hffff;
    nt.flag = kind == 3 ? top : kind == 4 ? s[8] ^ s[5] :
      kind == 5 ? locked : 1'b0;
    nt.main = s[8:3] >= 6'h29; // Sector 48 up; region never main
    i_kind = kind;
    i_bank = 3'($urandom);
    i_sector_addr = s;
    i_word_mode = word;
    i_start = 1'b1;
    notes.push_back(nt);
    @(negedge i_ref_clk);
    i_start = 1'b0;
    for (n = 0; n < 100 && o_done !== 1'b1; n++) @(negedge i_ref_clk);
    if (n == 100) begin
      bad_count++;
      finish_test();
    end
  endtask
  // Each done pulse is matched to the oldest note
  always @(posedge i_ref_clk) begin
    if (o_done === 1'b1) begin
      if (notes.size() == 0) check("note", 16'h0001, 16'h0000);
      else begin
        nt = notes.pop_front();
        check("result", o_result & nt.mask, nt.val);
        check("flag", 16'(o_flag), 16'(nt.flag));
        check("main", 16'(o_main_sector), 16'(nt.main));
        check("busy", 16'(o_busy), 16'h0000);
      end
    end
  end
  initial begin
    void'($urandom(32'hfa87));
    repeat (8) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    // Every kind, both widths, both straps, back to back
    for (int i = 0; i < 32; i++) begin
      top = i[4];
      locked = ~i[4];
      read(i[2:0], i[3]);
    end
    $display("Test kinds done");
    for (int i = 0; i < 24; i++) begin
      locked = 1'($urandom);
      read(3'h4, 1'($urandom));
    end
    $display("Test protect verify done");
    // Reset in mid read must drop the pins at once
    i_kind = 3'h5;
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    repeat (30) @(negedge i_ref_clk);
    i_arst_n = 1'b0;
    #1;
    check("pins", {o_chip_sel_n, o_id_high_voltage}, 16'h0002);
    @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    read(3'h3, 1'b1);
    $display("Test abort done");
    repeat (4) @(negedge i_ref_clk);
    finish_test();
  end
endmodule // test_fidr_host
